/* hw/omc_pkg.sv */
/*
 * Constants and the operating-state type of the operating-mode controller.
 * Assumes a single 10 MHz main clock and synchronous software write strobes.
 */
package omc_pkg;
    // ****************************************************************
    // Operating states
    // ****************************************************************
    typedef enum logic [3:0] {
        RUN_HF_SINGLE, RUN_HF_DUAL, RUN_LF_HF_OFF, RUN_LF_HF_ON,
        DEEP_DOZE_HF, DOZE_HF_SINGLE, DOZE_HF_DUAL,
        DEEP_DOZE_LF, DOZE_LF_HF_OFF, DOZE_LF_HF_ON,
        POWER_DOWN, WARM_UP
    } omc_state_t;

    // ****************************************************************
    // Widths, reset values and timing
    // ****************************************************************
    localparam int TAP_W = 4;
    localparam int SEL_W = 2;
    localparam int WARM_W = 16;
    localparam logic [WARM_W-1:0] WARM_UP_CYCLES = 16'h0010;
    localparam logic [WARM_W-1:0] WARM_ZERO = 16'h0000;
    localparam logic [WARM_W-1:0] WARM_ONE = 16'h0001;
    localparam logic RST_HF_EN = 1'b1;
    localparam logic RST_LF_EN = 1'b0;
    localparam logic RST_CLK_SEL = 1'b0;
    localparam int MACHINE_CYCLE_STATES = 4;
endpackage

/* hw/omc_operating_mode_controller.sv */
/*
 * Operating-mode controller: state machine over run, doze, deep doze and
 * power-down, with oscillator, CPU, watchdog and peripheral clock controls.
 * Assumes the CPU presents system-control writes as one-cycle strobes and
 * all inputs are synchronous to clk.
 */
`timescale 1ns/100ps
module omc_operating_mode_controller (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // System control write
    input wire logic ctrlWrite,
    input wire logic haltReqIn,
    input wire logic gateReqIn,
    input wire logic mainClockSelectIn,
    input wire logic hfOscEnableIn,
    input wire logic lfOscEnableIn,
    input wire logic stopReqIn,
    input wire logic stopLevelRelease,
    input wire logic stopReturnSlow,
    // Wake sources
    input wire logic intRequest,
    input wire logic wakePin,
    input wire logic [omc_pkg::TAP_W-1:0] baseTimerTaps,
    input wire logic [omc_pkg::SEL_W-1:0] baseTimerSourceSelect,
    // Interrupt and timer enables
    input wire logic masterIntEnable,
    input wire logic baseTimerIntEnable,
    input wire logic baseTimerOn,
    // Control readback
    output omc_pkg::omc_state_t opState,
    output logic haltReq,
    output logic peripheralClockGate,
    output logic mainClockSelect,
    output logic hfOscEnable,
    output logic lfOscEnable,
    // Clock tree controls
    output logic hfOscRun,
    output logic lfOscRun,
    output logic lfPinsAsPort,
    output logic mainClockIsLf,
    output logic cpuRun,
    output logic watchdogRun,
    output logic peripheralClockOn,
    output logic baseTimerClockOn,
    output logic dividerLowHold,
    // Events to CPU and interrupt logic
    output logic cpuTakeInt,
    output logic cpuResumeNext,
    output logic baseTimerIntSet,
    output logic baseTimerService,
    output logic oscFailReset
);
    import omc_pkg::*;

    // ****************************************************************
    // State registers
    // ****************************************************************
    omc_state_t state, next_state;
    logic next_haltReq, next_gate, next_sel, next_hfEn, next_lfEn;
    logic relLevel, next_relLevel, retSlow, next_retSlow;
    logic timerOnAtEntry, next_timerOnAtEntry;
    logic latchPending, next_latchPending;
    logic next_takeInt, next_resume, next_intSet, next_service, next_fail;
    logic tapPrev, next_tapPrev, wakePrev, next_wakePrev;
    logic [WARM_W-1:0] warmCount, next_warmCount;
    logic tapNow, tapFall, wakeHit, failWrite, isDoze, isDeep, isRun;

    assign tapNow = baseTimerTaps[baseTimerSourceSelect];
    assign tapFall = tapPrev && !tapNow;
    assign wakeHit = relLevel ? wakePin : (wakePin && !wakePrev);
    // Clearing both enables, or the one feeding the main clock, is fatal
    assign failWrite = ctrlWrite && ((!hfOscEnableIn && !lfOscEnableIn)
        || (!hfOscEnableIn && !mainClockIsLf)
        || (!lfOscEnableIn && mainClockIsLf));
    assign isDoze = state inside {DOZE_HF_SINGLE, DOZE_HF_DUAL, DOZE_LF_HF_OFF, DOZE_LF_HF_ON};
    assign isDeep = state inside {DEEP_DOZE_HF, DEEP_DOZE_LF};
    assign isRun = state inside {RUN_HF_SINGLE, RUN_HF_DUAL, RUN_LF_HF_OFF, RUN_LF_HF_ON};

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb begin
        next_state = state;
        next_haltReq = haltReq;
        next_gate = peripheralClockGate;
        next_sel = mainClockSelect;
        next_hfEn = hfOscEnable;
        next_lfEn = lfOscEnable;
        next_relLevel = relLevel;
        next_retSlow = retSlow;
        next_timerOnAtEntry = timerOnAtEntry;
        next_latchPending = 1'b0;
        next_takeInt = 1'b0;
        next_resume = 1'b0;
        next_intSet = latchPending && isRun;
        next_service = 1'b0;
        next_fail = failWrite;
        next_tapPrev = tapNow;
        next_wakePrev = wakePin;
        next_warmCount = warmCount;
        if (failWrite) begin
            next_state = RUN_HF_SINGLE;
            next_haltReq = 1'b0;
            next_gate = 1'b0;
            next_sel = RST_CLK_SEL;
            next_hfEn = RST_HF_EN;
            next_lfEn = RST_LF_EN;
        end else if (ctrlWrite && isRun) begin
            next_sel = mainClockSelectIn;
            next_hfEn = hfOscEnableIn;
            next_lfEn = lfOscEnableIn;
            next_relLevel = stopLevelRelease;
            next_retSlow = stopReturnSlow;
            next_haltReq = haltReqIn;
            next_gate = gateReqIn;
            // Halt and gate together are illegal; halt is taken first
            if (stopReqIn) begin
                next_state = POWER_DOWN;
            end else if (haltReqIn) begin
                unique case (state)
                    RUN_HF_SINGLE: next_state = DOZE_HF_SINGLE;
                    RUN_HF_DUAL: next_state = DOZE_HF_DUAL;
                    RUN_LF_HF_OFF: next_state = DOZE_LF_HF_OFF;
                    default: next_state = DOZE_LF_HF_ON;
                endcase
            end else if (gateReqIn) begin
                // Entry does not depend on the timer enable
                next_timerOnAtEntry = baseTimerOn;
                next_state = mainClockIsLf ? DEEP_DOZE_LF : DEEP_DOZE_HF;
            end else begin
                unique case (state)
                    RUN_HF_SINGLE: if (lfOscEnableIn) next_state = RUN_HF_DUAL;
                    RUN_HF_DUAL: begin
                        if (mainClockSelectIn) begin
                            next_state = RUN_LF_HF_ON;
                        end else if (!lfOscEnableIn) begin
                            next_state = RUN_HF_SINGLE;
                        end
                    end
                    RUN_LF_HF_ON: begin
                        if (!mainClockSelectIn) begin
                            next_state = RUN_HF_DUAL;
                        end else if (!hfOscEnableIn) begin
                            next_state = RUN_LF_HF_OFF;
                        end
                    end
                    default: if (hfOscEnableIn) next_state = RUN_LF_HF_ON;
                endcase
            end
        end else if (isDoze && intRequest) begin
            next_haltReq = 1'b0;
            next_takeInt = masterIntEnable;
            next_resume = !masterIntEnable;
            unique case (state)
                DOZE_HF_SINGLE: next_state = RUN_HF_SINGLE;
                DOZE_HF_DUAL: next_state = RUN_HF_DUAL;
                DOZE_LF_HF_OFF: next_state = RUN_LF_HF_OFF;
                default: next_state = RUN_LF_HF_ON;
            endcase
        end else if (isDeep && tapFall) begin
            next_gate = 1'b0;
            next_latchPending = timerOnAtEntry;
            next_service = masterIntEnable && baseTimerIntEnable && timerOnAtEntry;
            next_state = (state == DEEP_DOZE_LF) ? RUN_LF_HF_OFF : RUN_HF_SINGLE;
        end else if (state == POWER_DOWN && wakeHit) begin
            next_warmCount = WARM_UP_CYCLES;
            next_state = WARM_UP;
        end else if (state == WARM_UP) begin
            if (warmCount == WARM_ONE) begin
                next_warmCount = WARM_ZERO;
                next_resume = 1'b1;
                next_state = retSlow ? RUN_LF_HF_OFF : RUN_HF_SINGLE;
            end else begin
                next_warmCount = warmCount - WARM_ONE;
            end
        end
    end

    // ****************************************************************
    // Registers, one state encoding for the whole controller
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state <= RUN_HF_SINGLE;
            haltReq <= 1'b0;
            peripheralClockGate <= 1'b0;
            mainClockSelect <= RST_CLK_SEL;
            hfOscEnable <= RST_HF_EN;
            lfOscEnable <= RST_LF_EN;
            relLevel <= 1'b0;
            retSlow <= 1'b0;
            timerOnAtEntry <= 1'b0;
            latchPending <= 1'b0;
            cpuTakeInt <= 1'b0;
            cpuResumeNext <= 1'b0;
            baseTimerIntSet <= 1'b0;
            baseTimerService <= 1'b0;
            oscFailReset <= 1'b0;
            tapPrev <= 1'b0;
            wakePrev <= 1'b0;
            warmCount <= WARM_ZERO;
        end else begin
            state <= next_state;
            haltReq <= next_haltReq;
            peripheralClockGate <= next_gate;
            mainClockSelect <= next_sel;
            hfOscEnable <= next_hfEn;
            lfOscEnable <= next_lfEn;
            relLevel <= next_relLevel;
            retSlow <= next_retSlow;
            timerOnAtEntry <= next_timerOnAtEntry;
            latchPending <= next_latchPending;
            cpuTakeInt <= next_takeInt;
            cpuResumeNext <= next_resume;
            baseTimerIntSet <= next_intSet;
            baseTimerService <= next_service;
            oscFailReset <= next_fail;
            tapPrev <= next_tapPrev;
            wakePrev <= next_wakePrev;
            warmCount <= next_warmCount;
        end
    end

    // ****************************************************************
    // Clock tree decode
    // ****************************************************************
    assign opState = state;
    assign mainClockIsLf = state inside {RUN_LF_HF_OFF, RUN_LF_HF_ON, DEEP_DOZE_LF,
        DOZE_LF_HF_OFF, DOZE_LF_HF_ON};
    // Slow deep doze keeps the fast oscillator only if software left it enabled
    assign hfOscRun = !(state inside {RUN_LF_HF_OFF, DOZE_LF_HF_OFF, POWER_DOWN})
        && !(state == DEEP_DOZE_LF && !hfOscEnable);
    assign lfOscRun = !(state inside {RUN_HF_SINGLE, DOZE_HF_SINGLE, POWER_DOWN, WARM_UP})
        && !(state == DEEP_DOZE_HF && !lfOscEnable);
    assign lfPinsAsPort = !lfOscRun;
    assign cpuRun = isRun;
    assign watchdogRun = isRun;
    assign peripheralClockOn = isRun || isDoze;
    assign baseTimerClockOn = isRun || isDoze || isDeep;
    // Slow main clock, except in slow run with fast on, leaves the first six divider stages frozen
    assign dividerLowHold = state inside {RUN_LF_HF_OFF, DOZE_LF_HF_OFF, DOZE_LF_HF_ON,
        DEEP_DOZE_LF};

    // ****************************************************************
    // Checks
    // ****************************************************************
    // Bound covers the warm-up count with slack for the return edge
    localparam int WARM_BOUND = 20;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // Reset itself is watched here, so it must not disable this one
    reset_run_state_a: assert property (@(posedge clk) disable iff (1'b0)
        !rstn |=> state == RUN_HF_SINGLE)
        else $error("reset did not give fast single run");

    halt_entry_a: assert property (state == RUN_HF_SINGLE && ctrlWrite && haltReqIn
        && !stopReqIn && !failWrite |=> state == DOZE_HF_SINGLE && !cpuRun)
        else $error("halt request did not enter single doze");

    doze_wake_a: assert property (state == DOZE_HF_SINGLE && intRequest
        |=> state == RUN_HF_SINGLE && !haltReq)
        else $error("doze did not wake on interrupt");

    wake_service_a: assert property (isDoze && intRequest
        |=> cpuTakeInt == $past(masterIntEnable) && cpuResumeNext != cpuTakeInt)
        else $error("wake action does not match master enable");

    deep_wake_a: assert property (state == DEEP_DOZE_HF && tapFall
        |=> state == RUN_HF_SINGLE && !peripheralClockGate)
        else $error("fast deep doze wake wrong");

    timer_latch_a: assert property (isDeep && tapFall && timerOnAtEntry
        |=> ##1 baseTimerIntSet)
        else $error("timer latch not set after deep doze");

    slow_switch_a: assert property (state == RUN_HF_DUAL && ctrlWrite
        && mainClockSelectIn && !haltReqIn && !gateReqIn && !stopReqIn && !failWrite
        |=> state == RUN_LF_HF_ON && mainClockIsLf)
        else $error("clock select did not reach slow run");

    osc_loss_a: assert property (ctrlWrite && !hfOscEnableIn && !lfOscEnableIn
        |=> oscFailReset && state == RUN_HF_SINGLE)
        else $error("oscillator loss did not reset");

    warm_resume_a: assert property (state == POWER_DOWN && wakeHit
        |=> state == WARM_UP ##[1:WARM_BOUND] cpuResumeNext)
        else $error("power-down wake did not resume in time");

    slow_deep_a: assert property (state == DEEP_DOZE_LF && tapFall
        |=> state == RUN_LF_HF_OFF && !peripheralClockGate)
        else $error("slow deep doze did not wake into slow run");

    service_gate_a: assert property (baseTimerService
        |-> $past(masterIntEnable) && $past(baseTimerIntEnable) && $past(timerOnAtEntry))
        else $error("timer service without all three enables");

    single_pins_a: assert property (state == RUN_HF_SINGLE
        |-> lfPinsAsPort && hfOscRun && !mainClockIsLf)
        else $error("single-clock run does not free the slow crystal pins");

    doze_cycle_c: cover property (state == DOZE_HF_DUAL ##1 state == RUN_HF_DUAL);
    deep_lf_c: cover property (state == DEEP_DOZE_LF ##1 state == RUN_LF_HF_OFF);
    power_down_c: cover property (state == WARM_UP ##1 state == RUN_HF_SINGLE);
    deep_hf_c: cover property (state == DEEP_DOZE_HF ##1 state == RUN_HF_SINGLE);
    single_doze_c: cover property (state == DOZE_HF_SINGLE ##1 state == RUN_HF_SINGLE);
endmodule

/* verification/omc_cpu_model.sv */
/*
 * CPU core and interrupt controller model: issues system-control writes and
 * interrupt requests towards the operating-mode controller.
 * Assumes a free-running clk; all requests change 10 ns after a rising edge.
 */
`timescale 1ns/100ps
module omc_cpu_model (
    // Clock
    input wire logic clk,
    // System control write
    output logic ctrlWrite,
    output logic haltReqIn,
    output logic gateReqIn,
    output logic mainClockSelectIn,
    output logic hfOscEnableIn,
    output logic lfOscEnableIn,
    output logic stopReqIn,
    output logic stopLevelRelease,
    output logic stopReturnSlow,
    // Interrupt request
    output logic intRequest
);
    // ****************************************************************
    // Idle levels
    // ****************************************************************
    initial begin
        ctrlWrite = 1'h0;
        {stopReqIn, haltReqIn, gateReqIn} = 3'h0;
        {mainClockSelectIn, hfOscEnableIn, lfOscEnableIn} = 3'h4;
        stopLevelRelease = 1'h1;
        stopReturnSlow = 1'h0;
        intRequest = 1'h0;
    end

    // ****************************************************************
    // Write order {stop, halt, gate, select, hf, lf}
    // ****************************************************************
    // Callers never set halt and gate together
    // Slow oscillator is never cleared while both run
    // Dual mode starts by enabling the slow oscillator first
    task automatic write(input logic [5:0] v);
        @(posedge clk);
        #10;
        ctrlWrite = 1'h1;
        {stopReqIn, haltReqIn, gateReqIn, mainClockSelectIn, hfOscEnableIn, lfOscEnableIn} = v;
        @(posedge clk);
        #10;
        ctrlWrite = 1'h0;
        // Data is stale once the strobe drops, so show the inverse
        {stopReqIn, haltReqIn, gateReqIn, mainClockSelectIn, hfOscEnableIn, lfOscEnableIn} = ~v;
    endtask

    // Wake sensing and return state ride along with the next write
    task automatic stopMode(input logic lvl, input logic slow);
        stopLevelRelease = lvl;
        stopReturnSlow = slow;
    endtask

    // One-cycle request, dropped after the next rising edge whether taken or not
    task automatic irq();
        @(posedge clk);
        #10;
        intRequest = 1'h1;
        @(posedge clk);
        #10;
        intRequest = 1'h0;
    endtask
endmodule

/* verification/tb.sv */
/*
 * Self-checking bench of the operating-mode controller.
 * Assumes a 10 MHz clock and the CPU model as the only source of writes.
 */
`timescale 1ns/100ps
module tb;
    import omc_pkg::*;
    logic clk, rstn, wakePin, masterIntEnable, baseTimerIntEnable, baseTimerOn;
    logic ctrlWrite, haltReqIn, gateReqIn, mainClockSelectIn, hfOscEnableIn, lfOscEnableIn;
    logic stopReqIn, stopLevelRelease, stopReturnSlow, intRequest;
    logic [TAP_W-1:0] taps;
    logic [SEL_W-1:0] tapSel;
    omc_state_t opState;
    logic haltReq, peripheralClockGate, mainClockSelect, hfOscEnable, lfOscEnable;
    logic hfOscRun, lfOscRun, lfPinsAsPort, mainClockIsLf, cpuRun, watchdogRun;
    logic peripheralClockOn, baseTimerClockOn, dividerLowHold;
    logic cpuTakeInt, cpuResumeNext, baseTimerIntSet, baseTimerService, oscFailReset;
    logic [4:0] seen;
    int badCount = 0;
    int samplesChecked = 0;

    omc_cpu_model cpu_i (.clk(clk), .ctrlWrite(ctrlWrite), .haltReqIn(haltReqIn),
        .gateReqIn(gateReqIn), .mainClockSelectIn(mainClockSelectIn),
        .hfOscEnableIn(hfOscEnableIn), .lfOscEnableIn(lfOscEnableIn), .stopReqIn(stopReqIn),
        .stopLevelRelease(stopLevelRelease), .stopReturnSlow(stopReturnSlow),
        .intRequest(intRequest));
    omc_operating_mode_controller omc_operating_mode_controller_i (.clk(clk), .rstn(rstn),
        .ctrlWrite(ctrlWrite), .haltReqIn(haltReqIn), .gateReqIn(gateReqIn),
        .mainClockSelectIn(mainClockSelectIn), .hfOscEnableIn(hfOscEnableIn),
        .lfOscEnableIn(lfOscEnableIn), .stopReqIn(stopReqIn),
        .stopLevelRelease(stopLevelRelease), .stopReturnSlow(stopReturnSlow),
        .intRequest(intRequest), .wakePin(wakePin), .baseTimerTaps(taps),
        .baseTimerSourceSelect(tapSel), .masterIntEnable(masterIntEnable),
        .baseTimerIntEnable(baseTimerIntEnable), .baseTimerOn(baseTimerOn),
        .opState(opState), .haltReq(haltReq), .peripheralClockGate(peripheralClockGate),
        .mainClockSelect(mainClockSelect), .hfOscEnable(hfOscEnable),
        .lfOscEnable(lfOscEnable), .hfOscRun(hfOscRun), .lfOscRun(lfOscRun),
        .lfPinsAsPort(lfPinsAsPort), .mainClockIsLf(mainClockIsLf), .cpuRun(cpuRun),
        .watchdogRun(watchdogRun), .peripheralClockOn(peripheralClockOn),
        .baseTimerClockOn(baseTimerClockOn), .dividerLowHold(dividerLowHold),
        .cpuTakeInt(cpuTakeInt), .cpuResumeNext(cpuResumeNext),
        .baseTimerIntSet(baseTimerIntSet), .baseTimerService(baseTimerService),
        .oscFailReset(oscFailReset));

    // ****************************************************************
    // Clock and pulse capture
    // ****************************************************************
    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end
    // Pulses are caught sticky, so their exact cycle is not pinned here
    always @(posedge clk) begin
        seen = seen | {cpuTakeInt, cpuResumeNext, baseTimerIntSet, baseTimerService, oscFailReset};
    end

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic check(input logic [3:0] got, input logic [3:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            badCount++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask
    task automatic ws(input logic [5:0] v, input omc_state_t s);
        cpu_i.write(v);
        check(opState, s);
    endtask
    task automatic wakeInt(input omc_state_t s);
        cpu_i.irq();
        check(opState, s);
    endtask
    task automatic conclude();
        $display("checks=%0d errors=%0d", samplesChecked, badCount);
        if (badCount == 0 && samplesChecked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset();
        check(opState, RUN_HF_SINGLE);
        check({hfOscEnable, lfOscEnable, haltReq, peripheralClockGate}, 4'h8);
        check({hfOscRun, lfOscRun, lfPinsAsPort, cpuRun}, 4'hB);
        check(mainClockIsLf, 1'h0);
    endtask
    task automatic t_doze(input logic master_int_enable);
        masterIntEnable = master_int_enable;
        seen = 5'h00;
        ws(6'h12, DOZE_HF_SINGLE);
        check({cpuRun, watchdogRun, peripheralClockOn, hfOscRun}, 4'h3);
        check({haltReq, peripheralClockGate}, 4'h2);
        step(3);
        check(opState, DOZE_HF_SINGLE);
        wakeInt(RUN_HF_SINGLE);
        check(haltReq, 1'h0);
        step(3);
        check(seen[4:3], {master_int_enable, ~master_int_enable});
    endtask
    task automatic t_deep(input logic on);
        {masterIntEnable, baseTimerIntEnable, baseTimerOn} = {2'h3, on};
        tapSel = 2'h2;
        taps = 4'hF;
        seen = 5'h00;
        ws(6'h0A, DEEP_DOZE_HF);
        check({cpuRun, peripheralClockOn, baseTimerClockOn, hfOscRun}, 4'h3);
        check({peripheralClockGate, haltReq}, 4'h2);
        taps = 4'hE;
        step(3);
        check(opState, DEEP_DOZE_HF);
        taps = 4'hA;
        step(1);
        check(opState, RUN_HF_SINGLE);
        check({peripheralClockGate, peripheralClockOn}, 4'h1);
        step(3);
        check(seen[2:1], {on, on});
    endtask
    task automatic t_dual();
        ws(6'h03, RUN_HF_DUAL);
        check({lfOscRun, lfPinsAsPort, mainClockIsLf, hfOscRun}, 4'h9);
        ws(6'h07, RUN_LF_HF_ON);
        check(mainClockIsLf, 1'h1);
        check(mainClockSelect, 1'h1);
        ws(6'h05, RUN_LF_HF_OFF);
        check({hfOscRun, dividerLowHold, lfOscRun, cpuRun}, 4'h7);
        ws(6'h15, DOZE_LF_HF_OFF);
        check({cpuRun, watchdogRun, dividerLowHold, lfOscRun}, 4'h3);
        wakeInt(RUN_LF_HF_OFF);
        ws(6'h07, RUN_LF_HF_ON);
        ws(6'h17, DOZE_LF_HF_ON);
        check({hfOscRun, dividerLowHold, cpuRun}, 4'h6);
        wakeInt(RUN_LF_HF_ON);
        ws(6'h03, RUN_HF_DUAL);
        ws(6'h13, DOZE_HF_DUAL);
        check({cpuRun, watchdogRun, peripheralClockOn}, 4'h1);
        wakeInt(RUN_HF_DUAL);
        ws(6'h07, RUN_LF_HF_ON);
        ws(6'h05, RUN_LF_HF_OFF);
        taps = 4'hF;
        baseTimerOn = 1'h1;
        seen = 5'h00;
        ws(6'h0D, DEEP_DOZE_LF);
        check({dividerLowHold, hfOscRun, peripheralClockGate}, 4'h5);
        taps = 4'hB;
        step(1);
        check(opState, RUN_LF_HF_OFF);
        step(3);
        check(seen[2], 1'h1);
        ws(6'h04, RUN_HF_SINGLE);
        step(2);
        check({seen[0], hfOscEnable, lfOscEnable}, 4'h6);
        // Clearing only the enable of the oscillator feeding the main clock
        ws(6'h03, RUN_HF_DUAL);
        seen = 5'h00;
        ws(6'h01, RUN_HF_SINGLE);
        step(2);
        check({seen[0], hfOscEnable, lfOscEnable}, 4'h6);
    endtask
    task automatic t_rerst();
        ws(6'h12, DOZE_HF_SINGLE);
        rstn = 1'h0;
        step(2);
        rstn = 1'h1;
        check(opState, RUN_HF_SINGLE);
        check({hfOscEnable, lfOscEnable, haltReq, cpuRun}, 4'h9);
    endtask
    task automatic t_stop();
        seen = 5'h00;
        ws(6'h22, POWER_DOWN);
        check({hfOscRun, lfOscRun, cpuRun, peripheralClockOn}, 4'h0);
        step(4);
        check(opState, POWER_DOWN);
        wakePin = 1'h1;
        step(1);
        check(opState, WARM_UP);
        wakePin = 1'h0;
        step(int'(WARM_UP_CYCLES) - 1);
        check(opState, WARM_UP);
        step(1);
        check(opState, RUN_HF_SINGLE);
        step(1);
        check(seen[3], 1'h1);
        // Edge wake from slow run: a pin already high must not wake it
        ws(6'h03, RUN_HF_DUAL);
        ws(6'h07, RUN_LF_HF_ON);
        ws(6'h05, RUN_LF_HF_OFF);
        cpu_i.stopMode(1'h0, 1'h1);
        wakePin = 1'h1;
        ws(6'h25, POWER_DOWN);
        step(3);
        check(opState, POWER_DOWN);
        wakePin = 1'h0;
        step(1);
        check(opState, POWER_DOWN);
        wakePin = 1'h1;
        step(1);
        check(opState, WARM_UP);
        step(int'(WARM_UP_CYCLES));
        check(opState, RUN_LF_HF_OFF);
    endtask

    // ****************************************************************
    // Main sequence and watchdog
    // ****************************************************************
    initial begin
        {rstn, wakePin, masterIntEnable, baseTimerIntEnable, baseTimerOn} = 5'h00;
        taps = 4'hF;
        tapSel = 2'h2;
        seen = 5'h00;
        repeat (2) @(posedge clk);
        #10;
        rstn = 1'h1;
        t_reset();
        t_doze(1'h1);
        t_doze(1'h0);
        t_deep(1'h1);
        t_deep(1'h0);
        t_dual();
        t_rerst();
        t_stop();
        conclude();
    end
    // Whole run is about 140 cycles; this allows about twenty times that
    initial begin
        #(3000 * 100);
        badCount++;
        conclude();
    end
endmodule
